// ---- pss_status_summary.sv ----
// PHY status summary register, bits 15 down to 7
`timescale 1ns/1ps
module pss_status_summary #(
   parameter int ADDR_W = pss_pkg::ADDR_W
) (
   input  wire logic              sys_clk_in,
   input  wire logic              rstn_in,
   input  wire logic              reg_rd_in,
   input  wire logic              reg_wr_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [15:0]       reg_wdata_in,
   input  wire logic              auto_crossover_enable_in,
   input  wire logic              crossover_force_in,
   input  wire logic              crossover_alg_swapped_in,
   input  wire logic              rx_error_event_in,
   input  wire logic              false_carrier_event_in,
   input  wire logic              polarity_inverted_event_in,
   input  wire logic              signal_detect_raw_in,
   input  wire logic              descrambler_lock_in,
   input  wire logic              sd_qualify_enable_in,
   input  wire logic              page_received_event_in,
   input  wire logic              interrupt_event_in,
   output logic [15:0]            reg_rdata_out,
   output logic                   interrupt_pending_out
);
   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W != pss_pkg::ADDR_W) begin : g_bad_addr_w
      $error("Register address width must be five bits");
   end

   logic [1:0]  rst_sync_r;
   logic        rst_n_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [15:0] summary;
   logic        xover_live;
   logic        sig_det_live;
   logic        rd_summary;
   logic        rd_rxerr;
   logic        rd_fcar;
   logic        rd_ten;
   logic        rd_an_exp;
   logic        rd_int;
   logic        rxerr_flag;
   logic        fcar_flag;
   logic        pol_flag;
   logic        sig_det_flag;
   logic        lock_flag;
   logic        page_flag;
   logic        int_flag;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Two stages so release never lands near a clock edge
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_r <= pss_pkg::SYNC_RST;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n_r = rst_sync_r[1];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Strobe passed in so every assign sees it change
   function automatic logic hit(input logic              rd,
                                input logic [ADDR_W-1:0] addr,
                                input logic [4:0]        target);
      hit = rd && (addr == target);
   endfunction

   assign rd_summary = hit(reg_rd_in, reg_addr_in, pss_pkg::ADDR_SUMMARY);
   assign rd_rxerr   = hit(reg_rd_in, reg_addr_in, pss_pkg::ADDR_RXERR_CNT);
   assign rd_fcar    = hit(reg_rd_in, reg_addr_in, pss_pkg::ADDR_FCAR_CNT);
   assign rd_ten     = hit(reg_rd_in, reg_addr_in, pss_pkg::ADDR_TEN_STAT);
   assign rd_an_exp  = hit(reg_rd_in, reg_addr_in, pss_pkg::ADDR_AN_EXP);
   assign rd_int     = hit(reg_rd_in, reg_addr_in, pss_pkg::ADDR_INT_STAT);

   // ----------------------------------------------------------------
   // Live conditions
   // ----------------------------------------------------------------
   // control bits steer
   always_comb begin
      if (crossover_force_in) begin
         xover_live = 1'b1;
      end else if (auto_crossover_enable_in) begin
         xover_live = crossover_alg_swapped_in;
      end else begin
         xover_live = 1'b0;
      end
   end

   assign sig_det_live = signal_detect_raw_in &
                         (descrambler_lock_in | ~sd_qualify_enable_in);

   // ----------------------------------------------------------------
   // Latched flags
   // ----------------------------------------------------------------
   // receive error latch
   pss_flag_latch #(.LATCH_HIGH(1'b1)) u_rxerr (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (rx_error_event_in),
      .clear_in (rd_rxerr),
      .flag_out (rxerr_flag)
   );
   pss_flag_latch #(.LATCH_HIGH(1'b1)) u_fcar (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (false_carrier_event_in),
      .clear_in (rd_fcar),
      .flag_out (fcar_flag)
   );
   pss_flag_latch #(.LATCH_HIGH(1'b1)) u_pol (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (polarity_inverted_event_in),
      .clear_in (rd_ten),
      .flag_out (pol_flag)
   );
   pss_flag_latch #(.LATCH_HIGH(1'b0)) u_sig_det (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (sig_det_live),
      .clear_in (rd_summary),
      .flag_out (sig_det_flag)
   );
   pss_flag_latch #(.LATCH_HIGH(1'b0)) u_lock (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (descrambler_lock_in),
      .clear_in (rd_summary),
      .flag_out (lock_flag)
   );
   pss_flag_latch #(.LATCH_HIGH(1'b1)) u_page (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (page_received_event_in),
      .clear_in (rd_an_exp),
      .flag_out (page_flag)
   );
   pss_flag_latch #(.LATCH_HIGH(1'b1)) u_int (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_r),
      .cond_in  (interrupt_event_in),
      .clear_in (rd_int),
      .flag_out (int_flag)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Lower bits belong to other logic and read zero here
   always_comb begin
      summary = pss_pkg::RDATA_RST;
      summary[pss_pkg::BIT_RESERVED]  = 1'b0;
      summary[pss_pkg::BIT_XOVER]     = xover_live;
      summary[pss_pkg::BIT_RXERR]     = rxerr_flag;
      summary[pss_pkg::BIT_POLARITY]  = pol_flag;
      summary[pss_pkg::BIT_FCAR]      = fcar_flag;
      summary[pss_pkg::BIT_SIG_DET]   = sig_det_flag;
      summary[pss_pkg::BIT_DESC_LOCK] = lock_flag;
      summary[pss_pkg::BIT_PAGE_RX]   = page_flag;
      summary[pss_pkg::BIT_INT_PEND]  = int_flag;
   end

   // Writes are ignored: the register is read only
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_summary) begin
         rdata_nxt = summary;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= pss_pkg::RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_out         = rdata_r;
   assign interrupt_pending_out = int_flag;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_RESERVED_ZERO: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      !reg_rdata_out[pss_pkg::BIT_RESERVED])
      else $error("Reserved bit read as one");
   AST_XOVER_VALUE: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      rd_summary |=> reg_rdata_out[pss_pkg::BIT_XOVER] ==
         $past(crossover_force_in | (auto_crossover_enable_in &
         crossover_alg_swapped_in)))
      else $error("Crossover bit wrong");
   AST_XOVER_OFF: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (rd_summary && !auto_crossover_enable_in && !crossover_force_in)
      |=> !reg_rdata_out[pss_pkg::BIT_XOVER])
      else $error("Crossover set while disabled");
   AST_XOVER_LIVE: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (rd_summary && auto_crossover_enable_in && !crossover_force_in)
      |=> reg_rdata_out[pss_pkg::BIT_XOVER] ==
          $past(crossover_alg_swapped_in))
      else $error("Crossover not tracking");
   AST_RXERR_HOLD: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      rx_error_event_in ##1 (!rd_rxerr)[*3] |-> rxerr_flag)
      else $error("Receive error latch lost");
   AST_RXERR_CLEAR: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (rd_rxerr && !rx_error_event_in) |=> !rxerr_flag)
      else $error("Receive error latch not cleared");
   AST_POL_KEEP: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (pol_flag && !rd_ten) |=> pol_flag)
      else $error("Polarity cleared without its read");
   AST_POL_SET: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      polarity_inverted_event_in |=> pol_flag)
      else $error("Polarity event not latched");
   AST_FCAR_SET: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      false_carrier_event_in |=> fcar_flag)
      else $error("False carrier not latched");
   AST_SIGDET_LOW: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (sd_qualify_enable_in && !descrambler_lock_in) |=> !sig_det_flag)
      else $error("Signal detect ignores lock");
   AST_LOCK_LATCH: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (!descrambler_lock_in ##1 (descrambler_lock_in && !rd_summary)[*2])
      |-> !lock_flag)
      else $error("Lock loss not held");
   AST_LL_REARM: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (rd_summary && descrambler_lock_in) |=> lock_flag)
      else $error("Lock bit not rearmed after read");
   AST_PAGE_KEEP: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (page_flag && rd_summary) |=> page_flag)
      else $error("Summary read cleared page bit");
   AST_INT_READ: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      rd_summary |=> reg_rdata_out[pss_pkg::BIT_INT_PEND] == $past(int_flag))
      else $error("Interrupt bit misreported");
   AST_INT_CLEAR: assert property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      (rd_int && !interrupt_event_in) |=> !interrupt_pending_out)
      else $error("Interrupt not cleared by status read");
   COV_RXERR_CYCLE: cover property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      rxerr_flag ##1 rd_rxerr ##1 !rxerr_flag);
   COV_LOCK_LOSS_READ: cover property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      !lock_flag && rd_summary ##1 lock_flag);
   COV_INT_SERVICE: cover property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      interrupt_pending_out ##[1:4] rd_int ##1 !interrupt_pending_out);
   COV_XOVER_SWAP: cover property (
      @(posedge sys_clk_in) disable iff (!rst_n_r)
      rd_summary && reg_wr_in == 1'b0 && xover_live);
endmodule // pss_status_summary

// ---- pss_pkg.sv ----
// Constants for the PHY status summary register, upper bits
package pss_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 5;
   localparam logic [4:0]  ADDR_SUMMARY    = 5'h10;
   localparam logic [4:0]  ADDR_RXERR_CNT  = 5'h15;
   localparam logic [4:0]  ADDR_FCAR_CNT   = 5'h14;
   localparam logic [4:0]  ADDR_AN_EXP     = 5'h06;
   localparam logic [4:0]  ADDR_INT_STAT   = 5'h12;
   localparam logic [4:0]  ADDR_TEN_STAT   = 5'h1a;

   // ----------------------------------------------------------------
   // Field positions in the summary register
   // ----------------------------------------------------------------
   localparam int          DATA_W          = 16;
   localparam int          BIT_RESERVED    = 15;
   localparam int          BIT_XOVER       = 14;
   localparam int          BIT_RXERR       = 13;
   localparam int          BIT_POLARITY    = 12;
   localparam int          BIT_FCAR        = 11;
   localparam int          BIT_SIG_DET     = 10;
   localparam int          BIT_DESC_LOCK   = 9;
   localparam int          BIT_PAGE_RX     = 8;
   localparam int          BIT_INT_PEND    = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RDATA_RST       = 16'h0000;
   localparam logic        FLAG_RST        = 1'b0;
   localparam logic [1:0]  SYNC_RST        = 2'h0;

endpackage

// ---- pss_flag_latch.sv ----
// Single status flag, latching high or low; a read clears a high latch and rearms a low one
`timescale 1ns/1ps
module pss_flag_latch #(
   parameter bit LATCH_HIGH = 1'b1
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic cond_in,
   input  wire logic clear_in,
   output logic      flag_out
);
   logic flag_r;
   logic flag_nxt;

   // ----------------------------------------------------------------
   // Next value
   // ----------------------------------------------------------------
   // Condition wins over a clear in the same cycle
   always_comb begin
      if (LATCH_HIGH) begin
         flag_nxt = cond_in | (flag_r & ~clear_in);
      end else begin
         flag_nxt = cond_in & (flag_r | clear_in);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_r <= pss_pkg::FLAG_RST;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_out = flag_r;
endmodule // pss_flag_latch

// ---- pss_status_summary_bench.sv ----
// Self-checking bench for the PHY status summary register, upper bits
`timescale 1ns/1ps
module pss_status_summary_bench;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk;
   logic        rstn;
   logic        rd;
   logic        wr;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic        xo_en;
   logic        xo_force;
   logic        xo_swap;
   logic        rx_ev;
   logic        fc_ev;
   logic        pol_ev;
   logic        sd_raw;
   logic        lock;
   logic        qual;
   logic        page_ev;
   logic        int_ev;
   logic [15:0] rdata;
   logic        int_pend;
   int          bad_count;
   int          samples_checked;
   int          cyc;
   int          rel;
   logic [15:0] m_rdata;
   logic        m_rx, m_pol, m_fc, m_sd, m_lk, m_pg, m_ip;
   logic [4:0]  adr_tab [7];

   pss_status_summary dut (
      .sys_clk_in                 (clk),
      .rstn_in                    (rstn),
      .reg_rd_in                  (rd),
      .reg_wr_in                  (wr),
      .reg_addr_in                (addr),
      .reg_wdata_in               (wdata),
      .auto_crossover_enable_in   (xo_en),
      .crossover_force_in         (xo_force),
      .crossover_alg_swapped_in   (xo_swap),
      .rx_error_event_in          (rx_ev),
      .false_carrier_event_in     (fc_ev),
      .polarity_inverted_event_in (pol_ev),
      .signal_detect_raw_in       (sd_raw),
      .descrambler_lock_in        (lock),
      .sd_qualify_enable_in       (qual),
      .page_received_event_in     (page_ev),
      .interrupt_event_in         (int_ev),
      .reg_rdata_out              (rdata),
      .interrupt_pending_out      (int_pend)
   );

   // ------------------------------------------------------------
   // Reference model, updated on the same edge as the design
   // Nonblocking, so a reset at a falling edge cannot race the checks
   // ------------------------------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         m_rdata <= 16'h0000;
         {m_rx, m_pol, m_fc, m_sd, m_lk, m_pg, m_ip} <= 7'h00;
         rel <= 0;
      end else if (rel < 2) begin
         // Two edges of reset synchroniser before flags move
         rel <= rel + 1;
      end else begin
         if (rd && addr == pss_pkg::ADDR_SUMMARY)
            m_rdata <= {1'b0, xo_force | (xo_en & xo_swap), m_rx, m_pol,
                        m_fc, m_sd, m_lk, m_pg, m_ip, 7'h00};
         m_rx <= rx_ev | (m_rx & !(rd && addr == pss_pkg::ADDR_RXERR_CNT));
         m_fc <= fc_ev | (m_fc & !(rd && addr == pss_pkg::ADDR_FCAR_CNT));
         m_pol <= pol_ev | (m_pol & !(rd && addr == pss_pkg::ADDR_TEN_STAT));
         m_pg <= page_ev | (m_pg & !(rd && addr == pss_pkg::ADDR_AN_EXP));
         m_ip <= int_ev | (m_ip & !(rd && addr == pss_pkg::ADDR_INT_STAT));
         m_sd <= (sd_raw & (lock | !qual)) &
                 (m_sd | (rd && addr == pss_pkg::ADDR_SUMMARY));
         m_lk <= lock & (m_lk | (rd && addr == pss_pkg::ADDR_SUMMARY));
      end
   end

   // ------------------------------------------------------------
   // Compare tasks
   // ------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask

   // Compare at every falling edge, before new stimulus lands
   always @(negedge clk) begin
      chk_bit(rdata[15], m_rdata[15]);
      chk_bit(rdata[14], m_rdata[14]);
      chk_bit(rdata[13], m_rdata[13]);
      chk_bit(rdata[12], m_rdata[12]);
      chk_bit(rdata[11], m_rdata[11]);
      chk_bit(rdata[10], m_rdata[10]);
      chk_bit(rdata[9], m_rdata[9]);
      chk_bit(rdata[8], m_rdata[8]);
      chk_bit(rdata[7], m_rdata[7]);
      chk_bit(int_pend, m_ip);
      chk_word({9'h000, rdata[6:0]}, {9'h000, m_rdata[6:0]});
   end

   // ------------------------------------------------------------
   // Clock, timeout and closing report
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic conclude;
      $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Ceiling well above the roughly 3050 cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   task automatic quiet;
      {rd, wr, rx_ev, fc_ev, pol_ev, page_ev, int_ev} = 7'h00;
      {xo_en, xo_force, xo_swap, sd_raw, lock, qual} = 6'h00;
      addr = 5'h00;
      wdata = 16'h0000;
   endtask

   task automatic do_reset;
      rstn = 1'b0;
      quiet();
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      // Synchroniser needs two edges; leave a margin
      repeat (4) @(negedge clk);
   endtask

   task automatic rand_cycles(input int n);
      repeat (n) begin
         @(negedge clk);
         rd = 1'($urandom % 2);
         addr = adr_tab[$urandom % 7];
         wr = 1'($urandom % 4 == 0);
         wdata = 16'($urandom);
         rx_ev = 1'($urandom % 8 == 0);
         fc_ev = 1'($urandom % 8 == 0);
         pol_ev = 1'($urandom % 12 == 0);
         page_ev = 1'($urandom % 12 == 0);
         int_ev = 1'($urandom % 12 == 0);
         if ($urandom % 6 == 0) sd_raw = ~sd_raw;
         if ($urandom % 6 == 0) lock = ~lock;
         if ($urandom % 16 == 0) qual = ~qual;
         if ($urandom % 8 == 0) {xo_en, xo_force, xo_swap} = 3'($urandom);
      end
   endtask

   initial begin
      bad_count = 0;
      samples_checked = 0;
      cyc = 0;
      adr_tab = '{pss_pkg::ADDR_SUMMARY, pss_pkg::ADDR_RXERR_CNT,
                  pss_pkg::ADDR_FCAR_CNT, pss_pkg::ADDR_AN_EXP,
                  pss_pkg::ADDR_INT_STAT, pss_pkg::ADDR_TEN_STAT, 5'h1f};
      void'($urandom(32'hc54a1579));
      do_reset();
      // Every crossover control combination, back-to-back summary reads
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         {xo_en, xo_force, xo_swap} = 3'(i);
         rd = 1'b1;
         addr = pss_pkg::ADDR_SUMMARY;
      end
      // Writes to the summary address must change nothing
      @(negedge clk);
      rd = 1'b0;
      wr = 1'b1;
      wdata = 16'hffff;
      // Each latch set, then every clearing read in turn
      @(negedge clk);
      wr = 1'b0;
      {rx_ev, fc_ev, pol_ev, page_ev, int_ev} = 5'h1f;
      {sd_raw, lock} = 2'h3;
      for (int i = 0; i < 7; i++) begin
         @(negedge clk);
         {rx_ev, fc_ev, pol_ev, page_ev, int_ev} = 5'h00;
         rd = 1'b1;
         addr = adr_tab[i];
         @(negedge clk);
         addr = pss_pkg::ADDR_SUMMARY;
      end
      rand_cycles(1500);
      // Second reset in mid-run, one edge after the last random step
      @(negedge clk);
      do_reset();
      rand_cycles(1500);
      @(negedge clk);
      quiet();
      repeat (3) @(negedge clk);
      conclude();
   end

endmodule // pss_status_summary_bench
